/* File: wdt_pkg.sv */
// Constants and state type for the watchdog and reset controller
// Contract
// - Five sources hold the MPU in reset
// - Pin or supply fault halts digital logic
// - Pin or supply fault clears configuration space
// - Overflow resets the MPU briefly
// - Restart follows after 4100 crystal cycles
// - Overflow sets the battery-held overflow flag
// - Reset pin clears the overflow flag
// - Crystal stop sets flag, resets on resume
// - No internal state can disable watchdog
// - Disabling also drops supply fault detection
// - Writing refresh bit restarts the count
// - Wake low or emulator command restarts
// - Supply above threshold keeps logic running
// - Crystal clock is the time base
package wdt_pkg;

  // Time base and bus clock rates
  localparam int HCLK_HZ        = 20_000_000;
  localparam int XTAL_HZ        = 32768;
  // Watchdog period in its own unit
  localparam int WDT_PERIOD_MS  = 1500;
  localparam int WDT_TICKS_DEF  = XTAL_HZ * WDT_PERIOD_MS / 1000;
  // Crystal cycles from overflow to restart
  localparam int REL_TICKS_DEF  = 4100;
  // Crystal period in bus cycles, rounded down
  localparam int XTAL_PER_CYC   = HCLK_HZ / XTAL_HZ;
  // Slow crystal: no edge for two nominal periods
  localparam int MON_LIMIT_DEF  = 2 * XTAL_PER_CYC;

  // Counter widths
  localparam int WD_W           = 16;
  localparam int REL_W          = 13;
  localparam int MON_W          = 12;

  // Register byte addresses
  localparam logic [31:0] OFF_CTRL  = 32'h0000_0000;
  localparam logic [31:0] OFF_STAT  = 32'h0000_0004;
  localparam logic [31:0] OFF_MASK  = 32'h0000_0008;
  localparam logic [31:0] OFF_COUNT = 32'h0000_000c;
  localparam logic [31:0] CFG_INDEX = 32'h0000_2002;
  localparam logic [31:0] OFF_CFG   = 32'(CFG_INDEX * 4);

  // Field positions
  localparam int REFRESH_BIT    = 0;
  localparam int FLAG_BIT       = 2;
  localparam int EV_OVF_BIT     = 0;
  localparam int EV_FAULT_BIT   = 1;

  // Reset values
  localparam logic [1:0] IRQ_RST = 2'h0;

  // Emulator command that refreshes the watchdog
  localparam logic [7:0] EMU_CMD_REFRESH = 8'h14;

  // Watchdog sequencer states
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_REL   = 3'b010,
    ST_FAULT = 3'b100
  } wdt_state_type;

endpackage

/* File: hw_watchdog_reset_control.sv */
// Watchdog, crystal monitor and reset control with AHB-Lite registers
//
// Decided for this implementation: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module hw_watchdog_reset_control #(
  parameter int WDT_TICKS = wdt_pkg::WDT_TICKS_DEF,
  parameter int REL_TICKS = wdt_pkg::REL_TICKS_DEF,
  parameter int MON_LIMIT = wdt_pkg::MON_LIMIT_DEF
) (
  // Bus clock and power-on reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Reset and supply sources
  input  wire logic        ext_reset_in_n,
  input  wire logic        emu_reset_in_n,
  input  wire logic        supply_sense_below_bias,
  input  wire logic        supply_sense_at_main_rail,
  // Time base and refresh sources
  input  wire logic        crystal_clock,
  input  wire logic        wake,
  input  wire logic        emu_cmd_valid,
  input  wire logic [7:0]  emu_cmd,
  // Reset and interrupt outputs
  output logic             mpu_reset_n,
  output logic             digital_halt,
  output logic             irq
);

  // Parameter limits set by the fixed counter widths
  generate
    if (WDT_TICKS < 2 || WDT_TICKS > 65536 ||
        REL_TICKS < 1 || REL_TICKS > 8192 ||
        MON_LIMIT < 4 || MON_LIMIT > 4096) begin : g_bad
      $error("watchdog parameter out of range");
    end
  endgenerate

  // Terminal values of the counters
  localparam logic [15:0] WDT_LAST = 16'(WDT_TICKS - 1);
  localparam logic [12:0] REL_LAST = 13'(REL_TICKS - 1);
  localparam logic [11:0] MON_LAST = 12'(MON_LIMIT - 1);

  // Supply comparator, watchdog disable and reset nets
  wire wd_disable = supply_sense_at_main_rail;            // Debug only
  wire supply_low = supply_sense_below_bias & ~wd_disable;
  // Pin and supply act asynchronously; glitches reset too
  wire core_rst_n = hresetn & ext_reset_in_n & ~supply_low;
  // Battery-held flag survives a supply drop, not the pin
  wire flag_rst_n = hresetn & ext_reset_in_n;

  // Crystal synchroniser and edge detect
  logic xs1_q;           // First stage, read only by xs2_q
  logic xs2_q;           // Second stage
  logic xs3_q;           // Delayed copy for edge detect
  wire  tick;            // One bus cycle per crystal rising edge

  // Watchdog state
  wdt_pkg::wdt_state_type st_q;
  wdt_pkg::wdt_state_type st_d;
  logic [15:0] wd_q;     // Crystal ticks since last refresh
  logic [15:0] wd_d;
  logic [12:0] rel_q;    // Ticks spent in the release delay
  logic [12:0] rel_d;
  logic [11:0] mon_q;    // Bus cycles since last crystal edge
  logic [11:0] mon_d;
  logic        pend_q;   // Refresh write waiting for a tick
  logic        pend_d;
  logic        flag_q;   // Overflow flag
  logic        flag_d;

  // Register file
  logic [1:0]  irq_st_q; // Sticky events
  logic [1:0]  irq_st_d;
  logic [1:0]  irq_mk_q; // Event mask
  logic [31:0] rd_q;     // Read data for the data phase
  logic        w_ctrl_q; // Data-phase write selects
  logic        w_stat_q;
  logic        w_mask_q;
  logic        w_cfg_q;

  // Crystal edge seen in the bus domain
  assign tick = xs2_q & ~xs3_q;

  // Synchroniser runs from power-on so the monitor sees the crystal
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xs1_q <= 1'b0;
      xs2_q <= 1'b0;
      xs3_q <= 1'b0;
    end else begin
      xs1_q <= crystal_clock;
      xs2_q <= xs1_q;
      xs3_q <= xs2_q;
    end
  end

  // Crystal monitor: saturating count between edges
  wire mon_hit  = ~tick & (mon_q == MON_LAST);
  wire fault_ev = mon_hit & (st_q != wdt_pkg::ST_FAULT);
  assign mon_d  = tick ? 12'h000 :
                  (mon_q == MON_LAST) ? mon_q : 12'(mon_q + 12'h001);

  // Refresh sources; wake is a level, command a strobe
  wire emu_hit  = emu_cmd_valid & (emu_cmd == wdt_pkg::EMU_CMD_REFRESH);
  wire refr_wr  = w_ctrl_q & hwdata[wdt_pkg::REFRESH_BIT];
  // Bus write is held until the next crystal edge consumes it
  assign pend_d = refr_wr | (pend_q & ~tick);
  // Sense pin at the rail is the only disable; it parks the count at
  // zero, so no register bit can ever stop an overflow
  wire wd_clr   = (pend_q & tick) | ~wake | emu_hit |
                  wd_disable;

  // Overflow at the terminal count; nothing in software gates it
  wire in_run = (st_q == wdt_pkg::ST_RUN);
  wire ovf = in_run & tick & ~wd_clr & (wd_q == WDT_LAST);
  wire rel_done = (st_q == wdt_pkg::ST_REL) & tick & (rel_q == REL_LAST);

  // Watchdog counter: zero outside run, on refresh and on overflow
  assign wd_d = (!in_run || wd_clr || ovf) ? 16'h0000 :
                tick ? 16'(wd_q + 16'h0001) : wd_q;

  // Release delay counter
  assign rel_d = (st_q != wdt_pkg::ST_REL) ? 13'h0000 :
                 tick ? 13'(rel_q + 13'h0001) : rel_q;

  // Sequencer: run, hold in release, or wait for the crystal
  always_comb begin
    st_d = st_q;
    case (st_q)
      wdt_pkg::ST_RUN: begin
        if (mon_hit) begin
          st_d = wdt_pkg::ST_FAULT;
        end else if (ovf) begin
          st_d = wdt_pkg::ST_REL;
        end
      end
      wdt_pkg::ST_REL: begin
        if (mon_hit) begin
          st_d = wdt_pkg::ST_FAULT;
        end else if (rel_done) begin
          st_d = wdt_pkg::ST_RUN;
        end
      end
      wdt_pkg::ST_FAULT: begin
        // Crystal back: full restart through the release delay
        if (tick) begin
          st_d = wdt_pkg::ST_REL;
        end
      end
      default: begin
        st_d = wdt_pkg::ST_RUN;
      end
    endcase
  end

  // Watchdog registers, halted with the rest of the logic
  always_ff @(posedge hclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      st_q   <= wdt_pkg::ST_RUN;
      wd_q   <= 16'h0000;
      rel_q  <= 13'h0000;
      mon_q  <= 12'h000;
      pend_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      wd_q   <= wd_d;
      rel_q  <= rel_d;
      mon_q  <= mon_d;
      pend_q <= pend_d;
    end
  end

  // Overflow flag: set wins over a firmware clear in the same cycle
  wire flag_set = ovf | fault_ev;
  wire flag_clr = w_cfg_q & ~hwdata[wdt_pkg::FLAG_BIT];
  assign flag_d = flag_set | (flag_q & ~flag_clr);

  // Flag lives on its own reset so a supply drop keeps it
  always_ff @(posedge hclk or negedge flag_rst_n) begin
    if (!flag_rst_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // Address-phase decode
  wire ahb_go = hsel & hready & htrans[1];
  wire a_ctrl = (haddr == wdt_pkg::OFF_CTRL);
  wire a_stat = (haddr == wdt_pkg::OFF_STAT);
  wire a_mask = (haddr == wdt_pkg::OFF_MASK);
  wire a_cnt  = (haddr == wdt_pkg::OFF_COUNT);
  wire a_cfg  = (haddr == wdt_pkg::OFF_CFG);
  wire go_wr  = ahb_go & hwrite;
  wire go_rd  = ahb_go & ~hwrite;

  // Read mux; unmapped addresses and the refresh bit read zero
  wire [31:0] cfg_word = 32'(flag_q) << wdt_pkg::FLAG_BIT;
  wire [31:0] cnt_word = {3'h0, rel_q, wd_q};
  wire [31:0] rd_mux = a_stat ? {30'h0, irq_st_q} :
                       a_mask ? {30'h0, irq_mk_q} :
                       a_cnt  ? cnt_word :
                       a_cfg  ? cfg_word : 32'h0000_0000;

  // Sticky events; a write of one clears, a new event wins
  wire [1:0] ev  = {fault_ev, ovf};
  wire [1:0] w1c = w_stat_q ? hwdata[1:0] : 2'h0;
  assign irq_st_d = ev | (irq_st_q & ~w1c);

  // Bus side registers, cleared by pin or supply fault
  always_ff @(posedge hclk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      w_ctrl_q <= 1'b0;
      w_stat_q <= 1'b0;
      w_mask_q <= 1'b0;
      w_cfg_q  <= 1'b0;
      rd_q     <= 32'h0000_0000;
      irq_st_q <= wdt_pkg::IRQ_RST;
      irq_mk_q <= wdt_pkg::IRQ_RST;
    end else begin
      w_ctrl_q <= go_wr & a_ctrl;
      w_stat_q <= go_wr & a_stat;
      w_mask_q <= go_wr & a_mask;
      w_cfg_q  <= go_wr & a_cfg;
      rd_q     <= go_rd ? rd_mux : rd_q;
      irq_st_q <= irq_st_d;
      irq_mk_q <= w_mask_q ? hwdata[1:0] : irq_mk_q;
    end
  end

  // Zero-wait slave; the size is not checked, words only
  assign hrdata    = rd_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Reset outputs and interrupt
  assign mpu_reset_n = ext_reset_in_n & emu_reset_in_n &
                       ~supply_low & in_run;
  assign digital_halt = ~ext_reset_in_n | supply_low;
  assign irq = |(irq_st_q & irq_mk_q);

  // Checks on the watchdog sequencing
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!core_rst_n);

  sequence s_ovf;
    ovf;
  endsequence

  sequence s_hold;
    !mpu_reset_n [*2];
  endsequence

  ovf_flag_set_a: assert property (disable iff (!flag_rst_n)
    s_ovf |=> flag_q)
    else $error("overflow did not set the flag");

  ovf_mpu_hold_a: assert property (s_ovf |=> s_hold)
    else $error("overflow did not hold the MPU in reset");

  rel_restart_a: assert property (rel_done |=> in_run)
    else $error("release delay did not end in run");

  refresh_zero_a: assert property (pend_q && tick |=> wd_q == 0)
    else $error("refresh write did not zero the count");

  wake_zero_a: assert property (!wake |=> wd_q == 16'h0000)
    else $error("wake low did not zero the count");

  emu_zero_a: assert property (emu_hit |=> wd_q == 16'h0000)
    else $error("emulator command did not zero the count");

  // A supply drop after the fault resets the state, so the core reset
  // must disable this check as well
  fault_flag_a: assert property (
    fault_ev |=> flag_q && st_q == wdt_pkg::ST_FAULT)
    else $error("crystal fault not flagged");

  fault_resume_a: assert property (
    st_q == wdt_pkg::ST_FAULT && tick |=> st_q == wdt_pkg::ST_REL)
    else $error("crystal resume did not restart");

  count_up_a: assert property (
    in_run && tick && !wd_clr && !ovf |=> wd_q == $past(wd_q) + 16'h1)
    else $error("watchdog count did not advance");

  pin_flag_clr_a: assert property (disable iff (!hresetn)
    !ext_reset_in_n |=> !flag_q)
    else $error("reset pin did not clear the flag");

  supply_halt_a: assert property (disable iff (!hresetn)
    supply_low |-> digital_halt && !mpu_reset_n)
    else $error("supply fault did not halt");

endmodule

/* File: mpu_bus_model.sv */
// Firmware-side AHB-Lite master model for the watchdog block
`timescale 1ns/1ps
module mpu_bus_model (
  // Clock
  input  wire logic        hclk,
  // AHB-Lite master side
  output logic             hsel,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Raised when the slave never answers
  output logic             hang
);
  // Idle bus, word transfers only
  initial begin
    hsel   = 1'h0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    hang   = 1'h0;
  end
  // Next edge with hready high; bounded so a dead slave is caught
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'h1 && n < 32) begin
      n++;
      @(posedge hclk);
    end
    if (hready !== 1'h1) hang <= 1'h1;
  endtask
  // One single word transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'h1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready();
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    // Read data is taken at the closing edge of the data phase
    rd = hrdata;
  endtask
endmodule

/* File: hw_watchdog_reset_control_tb.sv */
// Self-checking bench for the watchdog and reset controller
`timescale 1ns/1ps
module hw_watchdog_reset_control_tb;
  localparam int WT = 16; // Short watchdog period, crystal ticks
  localparam int RT = 4;  // Short restart delay, crystal ticks
  localparam int ML = 40; // Crystal silence limit, above two periods
  localparam int HP = 4;  // Crystal half period in bus cycles
  localparam int TP = 2 * HP;
  // Pins and bus
  logic        hclk, hresetn, ext_n, emu_n, sup_low, sup_rail, xtal;
  logic        xtal_run, wake, ecv, mpu_reset_n, digital_halt, irq;
  logic        hready, hsel, hwrite, hang, hresp;
  logic [7:0]  ecmd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rv, rnd;
  // Behavioural model state and bookkeeping
  logic [31:0] exp_flag, exp_stat, exp_mask;
  int          num_errors, checked, low_cnt, n, k;

  hw_watchdog_reset_control #(.WDT_TICKS(WT), .REL_TICKS(RT),
    .MON_LIMIT(ML)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .ext_reset_in_n(ext_n),
    .emu_reset_in_n(emu_n), .supply_sense_below_bias(sup_low),
    .supply_sense_at_main_rail(sup_rail), .crystal_clock(xtal),
    .wake(wake), .emu_cmd_valid(ecv), .emu_cmd(ecmd),
    .mpu_reset_n(mpu_reset_n), .digital_halt(digital_halt), .irq(irq));
  mpu_bus_model mpu (.hclk(hclk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hang(hang));

  // Bus clock, 50 ns period
  initial begin
    hclk = 1'h0;
    forever #25 hclk = ~hclk;
  end
  // Crystal stands still while stopped, as a dead oscillator would
  initial begin
    xtal = 1'h0;
    forever begin
      repeat (HP) @(posedge hclk);
      if (xtal_run) xtal <= ~xtal;
    end
  end
  // Bus cycles with the MPU held in reset
  always @(posedge hclk) if (mpu_reset_n !== 1'h1) low_cnt++;
  // A hung bus ends the run
  always @(posedge hang) begin
    num_errors++;
    stop_test();
  end

  task automatic stop_test();
    if (num_errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic chk_bit(input string nm, input logic e, input logic s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e,
                    input string nm);
    mpu.xfer(1'h0, a, 32'h0, rv);
    chk(nm, e, rv);
    chk_bit("hresp", 1'h0, hresp);
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    mpu.xfer(1'h1, a, d, rv);
  endtask
  // Pins once settled; irq follows the model's status and mask
  task automatic pins(input logic r, input logic h);
    #1;
    chk_bit("mpu_reset_n", r, mpu_reset_n);
    chk_bit("digital_halt", h, digital_halt);
    chk_bit("irq", |(exp_stat & exp_mask), irq);
  endtask
  // Cycles until the MPU reset line reaches a level, bounded
  task automatic wait_mpu(input logic lvl, input int lim);
    for (n = 0; n < lim && mpu_reset_n !== lvl; n++) @(posedge hclk);
    if (n == lim) begin
      num_errors++;
      stop_test();
    end
  endtask

  initial begin
    {ext_n, emu_n, xtal_run, wake, hresetn} = 5'h1e;
    {sup_low, sup_rail, ecv, ecmd} = 11'h0;
    {num_errors, checked, low_cnt} = 0;
    {exp_flag, exp_stat, exp_mask} = 0;
    void'($urandom(21));
    repeat (10) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd(wdt_pkg::OFF_CFG, exp_flag, "flag");
    rd(wdt_pkg::OFF_STAT, exp_stat, "status");
    rnd = $urandom;
    exp_mask = rnd & 32'h3;
    wr(wdt_pkg::OFF_MASK, rnd);
    rd(wdt_pkg::OFF_MASK, exp_mask, "mask");
    rd(32'h0000_0100, 32'h0, "unmapped");
    exp_mask = 32'h3;
    wr(wdt_pkg::OFF_MASK, exp_mask);
    // Each refresh source in turn, spaced at random under one period
    low_cnt = 0;
    for (k = 0; k < 18; k++) begin
      repeat ($urandom_range(80, 40)) @(posedge hclk);
      case (k % 3)
        0: wr(wdt_pkg::OFF_CTRL, 32'h1);
        1: begin
          wake <= 1'h0;
          @(posedge hclk);
          wake <= 1'h1;
        end
        default: begin
          ecv <= 1'h1;
          ecmd <= wdt_pkg::EMU_CMD_REFRESH;
          @(posedge hclk);
          ecv <= 1'h0;
        end
      endcase
    end
    chk_bit("no reset while refreshed", 1'h1, low_cnt == 0);
    // Silent firmware; a foreign emulator command must not refresh
    wake <= 1'h0;
    @(posedge hclk);
    wake <= 1'h1;
    repeat (60) @(posedge hclk);
    rnd = $urandom;
    ecv <= 1'h1;
    ecmd <= (rnd[7:0] == wdt_pkg::EMU_CMD_REFRESH) ? 8'h41 : rnd[7:0];
    @(posedge hclk);
    ecv <= 1'h0;
    wait_mpu(1'h0, 400);
    k = n + 61;
    chk_bit("overflow delay", 1'h1, k >= WT*TP-TP && k <= WT*TP+TP+4);
    exp_flag = 32'h4;
    exp_stat = 32'h1;
    wait_mpu(1'h1, 200);
    chk_bit("restart delay", 1'h1,
            n >= RT*TP-TP && n <= RT*TP+4);
    // Wake held low keeps the count at zero during register checks
    wake <= 1'h0;
    pins(1'h1, 1'h0);
    rd(wdt_pkg::OFF_CFG, exp_flag, "flag");
    rd(wdt_pkg::OFF_CFG, exp_flag, "flag reread");
    rd(wdt_pkg::OFF_COUNT, 32'h0, "count");
    rd(wdt_pkg::OFF_STAT, exp_stat, "status");
    exp_mask = 32'h0;
    wr(wdt_pkg::OFF_MASK, exp_mask);
    pins(1'h1, 1'h0);
    exp_mask = 32'h3;
    wr(wdt_pkg::OFF_MASK, exp_mask);
    exp_stat = 32'h0;
    wr(wdt_pkg::OFF_STAT, 32'h1);
    pins(1'h1, 1'h0);
    exp_flag = 32'h0;
    wr(wdt_pkg::OFF_CFG, 32'h0);
    rd(wdt_pkg::OFF_CFG, exp_flag, "flag cleared");
    // Stopped crystal faults; restart follows once it resumes
    xtal_run <= 1'h0;
    wait_mpu(1'h0, ML + 3 * TP);
    {exp_flag, exp_stat} = {32'h4, 32'h2};
    pins(1'h0, 1'h0);
    xtal_run <= 1'h1;
    wait_mpu(1'h1, (RT + 2) * TP + 8);
    rd(wdt_pkg::OFF_STAT, exp_stat, "fault status");
    rd(wdt_pkg::OFF_CFG, exp_flag, "fault flag");
    // Reset pin halts logic and clears every register but the crystal synchroniser, and the flag
    ext_n <= 1'h0;
    {exp_flag, exp_stat, exp_mask} = 0;
    pins(1'h0, 1'h1);
    ext_n <= 1'h1;
    @(posedge hclk);
    rd(wdt_pkg::OFF_CFG, exp_flag, "flag");
    rd(wdt_pkg::OFF_STAT, exp_stat, "status");
    // Emulator reset holds the MPU only
    exp_mask = 32'h3;
    wr(wdt_pkg::OFF_MASK, exp_mask);
    emu_n <= 1'h0;
    pins(1'h0, 1'h0);
    emu_n <= 1'h1;
    @(posedge hclk);
    rd(wdt_pkg::OFF_MASK, exp_mask, "mask kept");
    // Low supply halts logic and clears registers
    sup_low <= 1'h1;
    exp_mask = 32'h0;
    pins(1'h0, 1'h1);
    sup_low <= 1'h0;
    @(posedge hclk);
    rd(wdt_pkg::OFF_MASK, exp_mask, "mask");
    pins(1'h1, 1'h0);
    // Sense pin at the rail: no supply fault and no watchdog
    {sup_rail, sup_low} <= 2'h3;
    pins(1'h1, 1'h0);
    wake <= 1'h1;
    low_cnt = 0;
    repeat (3 * WT * TP) @(posedge hclk);
    chk_bit("reset while disabled", 1'h1, low_cnt == 0);
    stop_test();
  end
endmodule
